// [pkg/haptic_seq_pkg.sv]
package haptic_seq_pkg;

    // Register map
    localparam logic [7:0] GO_REG_ADDR = 8'h0C;
    localparam int GO_BIT = 0;
    localparam logic [7:0] SLOT_FIRST_ADDR = 8'h0F;
    localparam logic [7:0] SLOT_LAST_ADDR = 8'h16;
    localparam logic [7:0] SEQUENCE_SLOT_THREE_ADDR = 8'h11;
    localparam logic [7:0] SEQUENCE_SLOT_FOUR_ADDR = 8'h12;
    localparam logic [7:0] SLOT_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // Slot layout
    localparam int SLOT_COUNT = 8;
    localparam logic [2:0] SLOT_FIRST_IDX = 3'h0;
    localparam logic [2:0] SLOT_LAST_IDX = 3'h7;
    localparam int DELAY_FLAG_BIT = 7;
    localparam logic [6:0] FIELD_ZERO = 7'h00;

    // Wait unit timing
    localparam int CLK_KHZ = 25000;
    localparam int WAIT_UNIT_MS = 10;
    localparam int UNIT_CYCLES = WAIT_UNIT_MS * CLK_KHZ;
    localparam int UNIT_CNT_W = 18;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_FETCH = 2'b01,
        SEQ_PLAY = 2'b10,
        SEQ_DELAY = 2'b11
    } seq_state_t;

    function automatic logic [6:0] slot_field(input logic [7:0] slot);
        return slot[6:0];
    endfunction

    function automatic logic slot_is_delay(input logic [7:0] slot);
        return slot[DELAY_FLAG_BIT];
    endfunction

    function automatic logic slot_is_end(input logic [7:0] slot);
        return slot[6:0] == FIELD_ZERO;
    endfunction

    function automatic logic is_slot_addr(input logic [7:0] addr);
        return (addr >= SLOT_FIRST_ADDR) && (addr <= SLOT_LAST_ADDR);
    endfunction

    function automatic logic [2:0] slot_index(input logic [7:0] addr);
        logic [7:0] diff;
        diff = addr - SLOT_FIRST_ADDR;
        return diff[2:0];
    endfunction

endpackage

// [src/sequence_slot_store.sv]
`timescale 1ns/1ps
module sequence_slot_store (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic wr_en_i,
    input wire logic [2:0] wr_idx_i,
    input wire logic [7:0] wdata_i,
    input wire logic [2:0] bus_idx_i,
    output logic [7:0] bus_slot_o,
    input wire logic [2:0] seq_idx_i,
    output logic [7:0] seq_slot_o
);
    logic [7:0] slots_q [haptic_seq_pkg::SLOT_COUNT];
    logic [7:0] slots_d [haptic_seq_pkg::SLOT_COUNT];

    always_comb begin
        for (int i = 0; i < haptic_seq_pkg::SLOT_COUNT; i++) begin
            slots_d[i] = slots_q[i];
        end
        if (wr_en_i) begin
            slots_d[wr_idx_i] = wdata_i;
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < haptic_seq_pkg::SLOT_COUNT; i++) begin
                slots_q[i] <= haptic_seq_pkg::SLOT_RESET;
            end
        end else begin
            for (int i = 0; i < haptic_seq_pkg::SLOT_COUNT; i++) begin
                slots_q[i] <= slots_d[i];
            end
        end
    end

    assign bus_slot_o = slots_q[bus_idx_i];
    assign seq_slot_o = slots_q[seq_idx_i];
endmodule

// [src/wait_unit_timer.sv]
`timescale 1ns/1ps
module wait_unit_timer #(
    parameter int UNIT_CYCLES = haptic_seq_pkg::UNIT_CYCLES
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic load_i,
    input wire logic [6:0] units_i,
    input wire logic abort_i,
    output logic done_o
);
    localparam logic [haptic_seq_pkg::UNIT_CNT_W-1:0] UNIT_RELOAD =
        haptic_seq_pkg::UNIT_CNT_W'(UNIT_CYCLES - 1);

    logic [haptic_seq_pkg::UNIT_CNT_W-1:0] cyc_q, cyc_d;
    logic [6:0] units_q, units_d;
    logic run_q, run_d;
    logic done_q, done_d;

    // The tick counter only runs inside a wait, so the timer outside a wait costs no toggling
    always_comb begin
        cyc_d = cyc_q;
        units_d = units_q;
        run_d = run_q;
        done_d = 1'b0;
        if (load_i) begin
            cyc_d = UNIT_RELOAD;
            units_d = units_i;
            run_d = 1'b1;
        end else if (abort_i) begin
            run_d = 1'b0;
        end else if (run_q) begin
            if (cyc_q != '0) begin
                cyc_d = cyc_q - 1'b1;
            end else if (units_q <= 7'h01) begin
                run_d = 1'b0;
                done_d = 1'b1;
            end else begin
                units_d = units_q - 7'h01;
                cyc_d = UNIT_RELOAD;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cyc_q <= '0;
            units_q <= 7'h00;
            run_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            cyc_q <= cyc_d;
            units_q <= units_d;
            run_q <= run_d;
            done_q <= done_d;
        end
    end

    assign done_o = done_q;

    AST_TIMER_RELOAD: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        load_i |=> run_q && cyc_q == UNIT_RELOAD && !done_q)
        else $error("wait counter not reloaded on entry");
endmodule

// [src/haptic_sequence_slots_three_four.sv]
`timescale 1ns/1ps
// Contract
// - Flag clear: the seven-bit field selects a library waveform to play.
// - Flag set in bit 7: the field is a wait, engine idles.
// - A wait lasts field value times ten milliseconds, then the next slot.
// - Flag 0 means waveform index, flag 1 means delay.
// - Playback starts at the first slot when software sets the go bit.
// - When a waveform ends, advance to the next slot if non-zero.
// - The sequence ends after the eighth slot even if all are non-zero.
// - A zero field stops the sequence, nothing more is played.
module haptic_sequence_slots_three_four #(
    parameter int UNIT_CYCLES = haptic_seq_pkg::UNIT_CYCLES
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic effect_done_i,
    output logic effect_start_o,
    output logic [6:0] effect_index_o,
    output logic engine_idle_o,
    output logic seq_busy_o,
    output logic [2:0] slot_pos_o
);
    haptic_seq_pkg::seq_state_t state_q, state_d;
    logic [2:0] pos_q, pos_d;
    logic go_q, go_d;
    logic start_q, start_d;
    logic [6:0] index_q, index_d;
    logic idle_q, idle_d;
    logic [6:0] units_q, units_d;
    logic [7:0] rdata_q, rdata_d;

    logic slot_wr;
    logic go_wr;
    logic [7:0] bus_slot;
    logic [7:0] cur_slot;
    logic timer_load;
    logic timer_done;
    logic advance;
    logic end_seq;

    assign slot_wr = wr_i && haptic_seq_pkg::is_slot_addr(addr_i);
    assign go_wr = wr_i && (addr_i == haptic_seq_pkg::GO_REG_ADDR);

    sequence_slot_store u_slots (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .wr_en_i(slot_wr),
        .wr_idx_i(haptic_seq_pkg::slot_index(addr_i)),
        .wdata_i(wdata_i),
        .bus_idx_i(haptic_seq_pkg::slot_index(addr_i)),
        .bus_slot_o(bus_slot),
        .seq_idx_i(pos_q),
        .seq_slot_o(cur_slot)
    );

    wait_unit_timer #(
        .UNIT_CYCLES(UNIT_CYCLES)
    ) u_timer (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .load_i(timer_load),
        .units_i(haptic_seq_pkg::slot_field(cur_slot)),
        .abort_i(!go_q),
        .done_o(timer_done)
    );

    // Register read port: data stands only in the cycle after the strobe
    always_comb begin
        rdata_d = haptic_seq_pkg::READ_ZERO;
        if (rd_i) begin
            if (haptic_seq_pkg::is_slot_addr(addr_i)) begin
                rdata_d = bus_slot;
            end else if (addr_i == haptic_seq_pkg::GO_REG_ADDR) begin
                rdata_d[haptic_seq_pkg::GO_BIT] = go_q;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_q <= haptic_seq_pkg::READ_ZERO;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Sequencer; slots may be rewritten during playback and count when fetched
    always_comb begin
        state_d = state_q;
        pos_d = pos_q;
        start_d = 1'b0;
        index_d = index_q;
        idle_d = idle_q;
        units_d = units_q;
        timer_load = 1'b0;
        advance = 1'b0;
        end_seq = 1'b0;
        case (state_q)
            haptic_seq_pkg::SEQ_IDLE: begin
                if (go_q) begin
                    pos_d = haptic_seq_pkg::SLOT_FIRST_IDX;
                    state_d = haptic_seq_pkg::SEQ_FETCH;
                end
            end
            haptic_seq_pkg::SEQ_FETCH: begin
                if (haptic_seq_pkg::slot_is_end(cur_slot)) begin
                    end_seq = 1'b1;
                end else if (haptic_seq_pkg::slot_is_delay(cur_slot)) begin
                    timer_load = 1'b1;
                    units_d = haptic_seq_pkg::slot_field(cur_slot);
                    idle_d = 1'b1;
                    state_d = haptic_seq_pkg::SEQ_DELAY;
                end else begin
                    start_d = 1'b1;
                    index_d = haptic_seq_pkg::slot_field(cur_slot);
                    state_d = haptic_seq_pkg::SEQ_PLAY;
                end
            end
            haptic_seq_pkg::SEQ_PLAY: begin
                advance = effect_done_i;
            end
            haptic_seq_pkg::SEQ_DELAY: begin
                advance = timer_done;
            end
            default: begin
                state_d = haptic_seq_pkg::SEQ_IDLE;
            end
        endcase
        if (advance) begin
            idle_d = 1'b0;
            if (pos_q == haptic_seq_pkg::SLOT_LAST_IDX) begin
                end_seq = 1'b1;
            end else begin
                pos_d = pos_q + 3'h1;
                state_d = haptic_seq_pkg::SEQ_FETCH;
            end
        end
        // Abort mid-fetch must not leave a half-set index or a running timer
        if (end_seq || (!go_q && state_q != haptic_seq_pkg::SEQ_IDLE)) begin
            state_d = haptic_seq_pkg::SEQ_IDLE;
            idle_d = 1'b0;
            start_d = 1'b0;
            index_d = index_q;
            timer_load = 1'b0;
        end
    end

    // A software write to the go bit wins over the end-of-sequence clear
    always_comb begin
        go_d = go_q;
        if (end_seq) begin
            go_d = 1'b0;
        end
        if (go_wr) begin
            go_d = wdata_i[haptic_seq_pkg::GO_BIT];
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= haptic_seq_pkg::SEQ_IDLE;
            pos_q <= haptic_seq_pkg::SLOT_FIRST_IDX;
            go_q <= 1'b0;
            start_q <= 1'b0;
            index_q <= 7'h00;
            idle_q <= 1'b0;
            units_q <= 7'h00;
        end else begin
            state_q <= state_d;
            pos_q <= pos_d;
            go_q <= go_d;
            start_q <= start_d;
            index_q <= index_d;
            idle_q <= idle_d;
            units_q <= units_d;
        end
    end

    assign rdata_o = rdata_q;
    assign effect_start_o = start_q;
    assign effect_index_o = index_q;
    assign engine_idle_o = idle_q;
    assign seq_busy_o = go_q;
    assign slot_pos_o = pos_q;

    // Helper: cycles spent since the wait was entered
    logic [31:0] wait_cyc_q, wait_cyc_d;

    always_comb begin
        wait_cyc_d = wait_cyc_q + 32'h0000_0001;
        if (state_q == haptic_seq_pkg::SEQ_FETCH) begin
            wait_cyc_d = 32'h0000_0000;
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wait_cyc_q <= 32'h0000_0000;
        end else begin
            wait_cyc_q <= wait_cyc_d;
        end
    end

    default clocking @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);

    sequence fetch_live;
        state_q == haptic_seq_pkg::SEQ_FETCH && go_q && !go_wr;
    endsequence

    sequence fetch_effect;
        fetch_live ##0 !haptic_seq_pkg::slot_is_end(cur_slot)
            ##0 !haptic_seq_pkg::slot_is_delay(cur_slot);
    endsequence

    sequence fetch_wait;
        fetch_live ##0 !haptic_seq_pkg::slot_is_end(cur_slot)
            ##0 haptic_seq_pkg::slot_is_delay(cur_slot);
    endsequence

    sequence slot_write;
        wr_i && (addr_i == haptic_seq_pkg::SEQUENCE_SLOT_THREE_ADDR
            || addr_i == haptic_seq_pkg::SEQUENCE_SLOT_FOUR_ADDR);
    endsequence

    AST_EFFECT_INDEX: assert property (
        fetch_effect |=> effect_start_o && effect_index_o == $past(cur_slot[6:0])
            && state_q == haptic_seq_pkg::SEQ_PLAY)
        else $error("waveform slot did not start its effect");

    AST_IDLE_NO_DRIVE: assert property (
        engine_idle_o |-> !effect_start_o && state_q == haptic_seq_pkg::SEQ_DELAY)
        else $error("effect started while engine idles");

    AST_WAIT_LENGTH: assert property (
        state_q == haptic_seq_pkg::SEQ_DELAY && timer_done |->
            wait_cyc_q == 32'(int'(units_q) * UNIT_CYCLES))
        else $error("wait length differs from field times unit");

    AST_FLAG_SELECTS_DELAY: assert property (
        fetch_wait |=> engine_idle_o && !effect_start_o ##1 !effect_start_o)
        else $error("delay slot treated as waveform");

    AST_GO_STARTS_FIRST: assert property (
        state_q == haptic_seq_pkg::SEQ_IDLE && go_q |=>
            state_q == haptic_seq_pkg::SEQ_FETCH && slot_pos_o == 3'h0)
        else $error("go did not start at first slot");

    AST_ADVANCE_NEXT: assert property (
        state_q == haptic_seq_pkg::SEQ_PLAY && effect_done_i && go_q && !go_wr
            && slot_pos_o != haptic_seq_pkg::SLOT_LAST_IDX |=>
            state_q == haptic_seq_pkg::SEQ_FETCH && slot_pos_o == $past(slot_pos_o) + 3'h1)
        else $error("sequencer did not advance to next slot");

    AST_STOP_AFTER_EIGHTH: assert property (
        state_q == haptic_seq_pkg::SEQ_PLAY && effect_done_i && !go_wr
            && slot_pos_o == haptic_seq_pkg::SLOT_LAST_IDX |=>
            state_q == haptic_seq_pkg::SEQ_IDLE && !seq_busy_o)
        else $error("sequence ran past the eighth slot");

    AST_ZERO_STOPS: assert property (
        fetch_live ##0 haptic_seq_pkg::slot_is_end(cur_slot) |=>
            state_q == haptic_seq_pkg::SEQ_IDLE && !effect_start_o && !engine_idle_o
            && !seq_busy_o)
        else $error("zero slot did not stop the sequence");

    AST_SLOT_READBACK: assert property (
        slot_write ##1 (rd_i && addr_i == $past(addr_i)) |=> rdata_o == $past(wdata_i, 2))
        else $error("slot read back differs from write");

    sequence play_hold;
        state_q == haptic_seq_pkg::SEQ_PLAY && go_q && !go_wr && !effect_done_i;
    endsequence

    AST_PLAY_WAITS_DONE: assert property (
        play_hold |=> state_q == haptic_seq_pkg::SEQ_PLAY && !effect_start_o
            && slot_pos_o == $past(slot_pos_o))
        else $error("sequencer left a waveform before it ended");

    AST_START_ONE_CYCLE: assert property (
        effect_start_o |=> !effect_start_o)
        else $error("effect start lasted more than one cycle");

    AST_INDEX_HOLDS: assert property (
        !effect_start_o |-> $stable(effect_index_o))
        else $error("waveform index changed without a start");

    AST_READ_ONE_CYCLE: assert property (
        !rd_i |=> rdata_o == haptic_seq_pkg::READ_ZERO)
        else $error("read data stood longer than one cycle");

    AST_GO_READBACK: assert property (
        rd_i && addr_i == haptic_seq_pkg::GO_REG_ADDR |=>
            rdata_o[haptic_seq_pkg::GO_BIT] == $past(seq_busy_o))
        else $error("go bit read back differs from busy state");

    AST_WAIT_HOLDS_SLOT: assert property (
        state_q == haptic_seq_pkg::SEQ_DELAY && !timer_done && go_q && !go_wr |=>
            engine_idle_o && slot_pos_o == $past(slot_pos_o))
        else $error("wait slot left before its time ran out");
endmodule

// [test/tb_haptic_sequence_slots_three_four.sv]
`timescale 1ns/1ps
module tb_haptic_sequence_slots_three_four;
    // Short wait unit keeps every delay slot to a few dozen cycles
    localparam int UC = 4;
    localparam int CYCLE_CEILING = 20000;

    logic mclk_i;
    logic reset_n_i;
    logic [7:0] addr_i;
    logic [7:0] wdata_i;
    logic wr_i;
    logic rd_i;
    logic [7:0] rdata_o;
    logic effect_done_i = 1'b0;
    logic effect_start_o;
    logic [6:0] effect_index_o;
    logic engine_idle_o;
    logic seq_busy_o;
    logic [2:0] slot_pos_o;

    int fail_count = 0;
    int num_checks = 0;
    int seed = 93;
    int cycles = 0;
    int idle_cnt = 0;
    int want_units = 0;
    logic [7:0] exp_rd[$];
    logic [15:0] exp_ev[$];
    logic [7:0] slots[8];
    logic [15:0] ev_note;
    logic [31:0] rnd;
    logic rd_seen = 1'b0;
    logic idle_seen = 1'b0;

    haptic_sequence_slots_three_four #(.UNIT_CYCLES(UC)) u_dut (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rdata_o(rdata_o),
        .effect_done_i(effect_done_i),
        .effect_start_o(effect_start_o),
        .effect_index_o(effect_index_o),
        .engine_idle_o(engine_idle_o),
        .seq_busy_o(seq_busy_o),
        .slot_pos_o(slot_pos_o)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // An empty queue yields a value no output can match, except a wait seen at slot 7
    function automatic logic [15:0] pop_ev();
        if (exp_ev.size() == 0) begin
            return 16'hFFFF;
        end
        return exp_ev.pop_front();
    endfunction

    function automatic logic [15:0] pop_rd();
        if (exp_rd.size() == 0) begin
            return 16'hFFFF;
        end
        return {8'h00, exp_rd.pop_front()};
    endfunction

    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end

    always @(posedge mclk_i) begin
        cycles++;
        if (cycles >= CYCLE_CEILING) begin
            fail_count++;
            tally_and_finish();
        end
    end

    // Watcher samples at the falling edge, where registered outputs are settled
    always @(negedge mclk_i) begin
        if (rd_seen) begin
            check({8'h00, rdata_o}, pop_rd());
        end
        rd_seen = (rd_i === 1'b1);
        if (effect_start_o === 1'b1) begin
            check({5'h00, slot_pos_o, 1'b0, effect_index_o}, pop_ev());
        end
        if (engine_idle_o === 1'b1 && !idle_seen) begin
            ev_note = pop_ev();
            check({5'h00, slot_pos_o, 1'b1, 7'h00}, ev_note & 16'h0780);
            want_units = int'(ev_note[6:0]);
            idle_cnt = 0;
        end
        if (engine_idle_o === 1'b1) begin
            idle_cnt++;
        end
        if (engine_idle_o !== 1'b1 && idle_seen) begin
            check(16'(idle_cnt), 16'(want_units * UC + 1));
        end
        idle_seen = (engine_idle_o === 1'b1);
    end

    // Library stand-in: ends each waveform after a random 1 to 4 cycles
    always begin
        @(negedge mclk_i);
        if (effect_start_o === 1'b1) begin
            repeat (1 + ($unsigned($random(seed)) % 4)) @(posedge mclk_i);
            effect_done_i <= 1'b1;
            @(posedge mclk_i);
            effect_done_i <= 1'b0;
        end
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        @(posedge mclk_i);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_rd.push_back(e);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        @(posedge mclk_i);
    endtask

    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
        exp_rd.push_back(d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        @(posedge mclk_i);
    endtask

    task automatic run_seq(input string name);
        int n;
        for (int i = 0; i < 8; i++) begin
            wr(haptic_seq_pkg::SLOT_FIRST_ADDR + 8'(i), slots[i]);
        end
        for (int i = 0; i < 8; i++) begin
            if (slots[i][6:0] == 7'h00) begin
                break;
            end
            exp_ev.push_back({5'h00, 3'(i), slots[i]});
        end
        wr(haptic_seq_pkg::GO_REG_ADDR, 8'h01);
        @(negedge mclk_i);
        check({15'h0000, seq_busy_o}, 16'h0001);
        n = 0;
        while (seq_busy_o !== 1'b0 && n < 5000) begin
            @(posedge mclk_i);
            n++;
        end
        repeat (3) @(posedge mclk_i);
        check({15'h0000, seq_busy_o}, 16'h0000);
        check(16'(exp_ev.size()), 16'h0000);
        rd(haptic_seq_pkg::GO_REG_ADDR, 8'h00);
        $display("Test %s done", name);
    endtask

    initial begin
        addr_i = 8'h00;
        wdata_i = 8'h00;
        wr_i = 1'b0;
        rd_i = 1'b0;
        reset_n_i = 1'b0;
        repeat (3) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        @(posedge mclk_i);
        rd(haptic_seq_pkg::SEQUENCE_SLOT_THREE_ADDR, haptic_seq_pkg::SLOT_RESET);
        rd(haptic_seq_pkg::SEQUENCE_SLOT_FOUR_ADDR, haptic_seq_pkg::SLOT_RESET);
        for (int k = 0; k < 4; k++) begin
            rnd = $random(seed);
            wr(haptic_seq_pkg::SEQUENCE_SLOT_THREE_ADDR, rnd[7:0]);
            wr(haptic_seq_pkg::SEQUENCE_SLOT_FOUR_ADDR, rnd[15:8]);
            rd(haptic_seq_pkg::SEQUENCE_SLOT_THREE_ADDR, rnd[7:0]);
            rd(haptic_seq_pkg::SEQUENCE_SLOT_FOUR_ADDR, rnd[15:8]);
            wr_rd(haptic_seq_pkg::SEQUENCE_SLOT_THREE_ADDR, rnd[23:16]);
            wr_rd(haptic_seq_pkg::SEQUENCE_SLOT_FOUR_ADDR, rnd[31:24]);
        end
        wr(8'h30, 8'hA5);
        rd(8'h30, 8'h00);
        $display("Test registers done");
        // Back-to-back waits in slots three and four force a timer reload
        slots = '{8'h05, 8'h11, 8'h81, 8'h83, 8'h22, 8'h33, 8'h44, 8'h7F};
        run_seq("eight slots");
        slots[3] = 8'h80;
        run_seq("stop at slot four");
        slots[2] = 8'h00;
        run_seq("stop at slot three");
        for (int k = 0; k < 4; k++) begin
            for (int i = 0; i < 8; i++) begin
                rnd = $random(seed);
                slots[i] = rnd[7] ? {5'h10, rnd[6:4] | 3'h1} : {1'b0, rnd[6:0] | 7'h01};
                if (rnd[15:12] == 4'h0) begin
                    slots[i] = 8'h00;
                end
            end
            run_seq("random slots");
        end
        tally_and_finish();
    end
endmodule
